/* hw/pe_status_map.vh */
// Constants for the element status word and special register bank
`ifndef PE_STATUS_MAP_VH
`define PE_STATUS_MAP_VH
// Bank geometry
`define SPECIAL_REGISTER_BANK_COUNT        32
`define SPECIAL_REGISTER_BANK_IDX_W        5
`define SPECIAL_REGISTER_BANK_STATUS_IDX   5'h00
`define GREG_BYTES        160
`define GREG_ADDR_W       8
`define ELEM_MEM_ADDR_W   32
// Status word bit positions
`define SW_ACC_LSB        0
`define SW_CARRY          1
`define SW_OVERFLOW       2
`define SW_ZERO           3
`define SW_NEGATIVE       4
`define SW_LOGIC          5
`define SW_ENABLE         6
`define SW_MEM_PERMIT     7
`define SW_TRANSMIT       8
`define SW_RECEIVE        9
`define SW_FETCH          10
`define SW_FP_LO          11
`define SW_INEXACT        11
`define SW_INVALID        12
`define SW_DIV_ZERO       13
`define SW_UNDERFLOW      14
`define SW_FP_OVERFLOW    15
`define SW_MESH_PAR       16
`define SW_ROUTER_PAR     17
`define SW_ECC_HARD       18
`define SW_ECC_SOFT       19
`define SW_ADDR_LIMIT     20
// Masks
`define SW_USER_MASK      32'h0000ffff
`define SW_WRITE_MASK     32'h001ff7ff
`define SW_RESET          32'h00000000
// Operand size codes for the general register bank
`define OPSZ_1            3'h0
`define OPSZ_8            3'h1
`define OPSZ_16           3'h2
`define OPSZ_32           3'h3
`define OPSZ_64           3'h4
`endif

/* hw/general_register_bank.v */
// Unstructured general register bank with 1 to 64-bit operand access
`timescale 1ns/1ps
`include "pe_status_map.vh"
module general_register_bank (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   input  wire        wr_en,
   input  wire [2:0]  wr_size,
   input  wire [10:0] wr_bit_addr,
   input  wire [63:0] wr_data,
   input  wire [2:0]  rd_size,
   input  wire [10:0] rd_bit_addr,
   output reg  [63:0] rd_data_ff,
   output wire        align_err
);
   // =========================================================
   // Storage
   // =========================================================
   reg [7:0] mem [0:`GREG_BYTES-1];
   integer   i;
   integer   j;

   // Byte count of an operand size
   function [3:0] size_bytes;
      input [2:0] sz;
      begin
         case (sz)
            `OPSZ_16: size_bytes = 4'h2;
            `OPSZ_32: size_bytes = 4'h4;
            `OPSZ_64: size_bytes = 4'h8;
            default:  size_bytes = 4'h1;
         endcase
      end
   endfunction

   // Multi-bit operands must sit on a byte boundary
   function misaligned;
      input [2:0]  sz;
      input [10:0] a;
      begin
         misaligned = (sz != `OPSZ_1) && (a[2:0] != 3'h0);
      end
   endfunction

   assign align_err = (wr_en && misaligned(wr_size, wr_bit_addr)) ||
                      misaligned(rd_size, rd_bit_addr);

   // Write path, byte-lane or single bit [R02]
   always @(posedge sys_clk) begin
      if (clk_en && wr_en && !misaligned(wr_size, wr_bit_addr)) begin
         if (wr_size == `OPSZ_1) begin
            mem[wr_bit_addr[10:3]][wr_bit_addr[2:0]] <= wr_data[0];
         end else begin
            for (i = 0; i < 8; i = i + 1)
               if (i < size_bytes(wr_size) && (wr_bit_addr[10:3] + i) < `GREG_BYTES)
                  mem[wr_bit_addr[10:3] + i] <= wr_data[i*8 +: 8];
         end
      end
   end

   // Registered read, little-endian lane order [R02]
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff <= 64'h0000000000000000;
      end else if (clk_en) begin
         rd_data_ff <= 64'h0000000000000000;
         if (rd_size == `OPSZ_1) begin
            rd_data_ff[0] <= mem[rd_bit_addr[10:3]][rd_bit_addr[2:0]];
         end else begin
            for (j = 0; j < 8; j = j + 1)
               if (j < size_bytes(rd_size) && (rd_bit_addr[10:3] + j) < `GREG_BYTES)
                  rd_data_ff[j*8 +: 8] <= mem[rd_bit_addr[10:3] + j];
         end
      end
   end
endmodule // general_register_bank

/* hw/special_register_bank.v */
// Special register entries 1 to 31; entry 0 lives in the status logic
`timescale 1ns/1ps
`include "pe_status_map.vh"
module special_register_bank (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   input  wire        wr_en,
   input  wire [4:0]  wr_idx,
   input  wire [31:0] wr_data,
   input  wire [4:0]  rd_idx,
   output wire [31:0] rd_data
);
   // =========================================================
   // Storage for implementation-defined entries
   // =========================================================
   reg [31:0] bank [1:`SPECIAL_REGISTER_BANK_COUNT-1];
   integer    i;

   // Write any entry except zero [R01]
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 1; i < `SPECIAL_REGISTER_BANK_COUNT; i = i + 1)
            bank[i] <= 32'h00000000;
      end else if (clk_en && wr_en && wr_idx != `SPECIAL_REGISTER_BANK_STATUS_IDX) begin
         bank[wr_idx] <= wr_data;
      end
   end

   assign rd_data = (rd_idx == `SPECIAL_REGISTER_BANK_STATUS_IDX) ? 32'h00000000 : bank[rd_idx]; // [R01]
endmodule // special_register_bank

/* hw/pe_status_word_flags.v */
// Element status word, flag update logic and fault requests of one element
`timescale 1ns/1ps
`include "pe_status_map.vh"
// Summary of operation
// R01 - Thirty-two 32-bit special registers; entry zero is the status word.
// R02 - General bank of at least 160 bytes, 1 to 64-bit operands.
// R03 - Bit 0 mirrors accumulator LSB; bits 1-4 hold C, V, Z, N.
// R04 - Bit 5 is the one-bit logical accumulator.
// R05 - Bit 6 enables register-to-register compute unless exempt.
// R06 - Bit 7 enables register-memory transfers unless exempt.
// R07 - Bit 8 transmit request; cleared on connection, kept if send failed.
// R08 - Bit 9 set when a router message was received.
// R09 - Bit 10 set when router fetch obtained data.
// R10 - Setting any fp flag raises a masked fault code request.
// R11 - IEEE mode: fp instructions only set flags; move clears.
// R12 - Legacy mode: every fp instruction rewrites all fp flags.
// R13 - Inexact flag bit 11 stays reserved in both modes.
// R14 - Bit 12 invalid, bit 14 underflow, bit 15 overflow.
// R15 - Bit 13 divide by zero; IEEE zero over zero counts invalid.
// R16 - Error bits update unmasked; hidden and unwritable in user mode.
// R17 - Bit 16 written by mesh transfers; a one raises mesh fault.
// R18 - Bit 17 written by router ops; a one raises router fault.
// R19 - Bit 18 sticky hard ECC; sets uncorrectable status flag.
// R20 - Bit 19 sticky soft ECC; soft flag, threshold by count.
// R21 - Bit 20 limit error on user indirect access; zero in supervisor.
// R22 - User access to supervisor memory region raises a limit fault.
module pe_status_word_flags (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        clk_en,
   input  wire        supervisor,
   input  wire        ieee_mode,
   input  wire        acc_lsb,
   input  wire        cc_wr,
   input  wire [3:0]  cc_in,
   input  wire        logic_wr,
   input  wire        logic_in,
   input  wire        compute_req,
   input  wire        compute_exempt,
   input  wire        mem_req,
   input  wire        mem_exempt,
   input  wire        router_open,
   input  wire        router_connected,
   input  wire        router_recv,
   input  wire        router_fetch_op,
   input  wire        router_fetch_ok,
   input  wire        fp_op,
   input  wire        fp_invalid,
   input  wire        fp_div_zero,
   input  wire        fp_zero_dividend,
   input  wire        fp_underflow,
   input  wire        fp_overflow,
   input  wire [4:0]  fault_mask_word,
   input  wire        mesh_op,
   input  wire        mesh_parity,
   input  wire        router_op,
   input  wire        router_parity,
   input  wire        mem_access,
   input  wire        ecc_hard,
   input  wire        ecc_soft,
   input  wire [15:0] soft_error_count,
   input  wire [15:0] soft_threshold,
   input  wire        indirect_access,
   input  wire [31:0] mem_addr,
   input  wire [31:0] limit_addr,
   input  wire        special_register_bank_wr,
   input  wire [4:0]  special_register_bank_wr_idx,
   input  wire [31:0] special_register_bank_wr_data,
   input  wire [4:0]  special_register_bank_rd_idx,
   output reg  [31:0] special_register_bank_rd_data_ff,
   input  wire        greg_wr,
   input  wire [2:0]  greg_wr_size,
   input  wire [10:0] greg_wr_addr,
   input  wire [63:0] greg_wr_data,
   input  wire [2:0]  greg_rd_size,
   input  wire [10:0] greg_rd_addr,
   output wire [63:0] greg_rd_data,
   output wire        greg_align_err,
   output wire [31:0] element_status_word,
   output wire        compute_allow,
   output wire        mem_allow,
   output reg  [4:0]  fault_code_word_ff,
   output reg         mesh_parity_fault_ff,
   output reg         router_parity_fault_ff,
   output reg         address_limit_error_ff,
   output reg         uncorrectable_status_flag_ff,
   output reg         soft_error_status_flag_ff,
   output reg         soft_threshold_flag_ff
);
   // =========================================================
   // State
   // =========================================================
   reg  [31:0] status_ff;
   reg  [31:0] nxt_status;
   reg  [4:0]  fp_new;
   reg  [4:0]  fp_set;
   reg         sw_wr;
   reg  [31:0] wr_mask;
   wire [31:0] srb_rd_data;
   wire        region_fault;
   wire        limit_hit;

   // Hide supervisor-only bits in user mode
   function [31:0] user_view;
      input [31:0] w;
      input        sup;
      begin
         user_view = sup ? (w & `SW_WRITE_MASK) : (w & `SW_USER_MASK);
      end
   endfunction

   // =========================================================
   // Sub-banks
   // =========================================================
   special_register_bank u_srb (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .wr_en   (special_register_bank_wr),
      .wr_idx  (special_register_bank_wr_idx),
      .wr_data (special_register_bank_wr_data),
      .rd_idx  (special_register_bank_rd_idx),
      .rd_data (srb_rd_data)
   );

   general_register_bank u_grb (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .wr_en       (greg_wr),
      .wr_size     (greg_wr_size),
      .wr_bit_addr (greg_wr_addr),
      .wr_data     (greg_wr_data),
      .rd_size     (greg_rd_size),
      .rd_bit_addr (greg_rd_addr),
      .rd_data_ff  (greg_rd_data),
      .align_err   (greg_align_err)
   );

   // =========================================================
   // Gating and address checks
   // =========================================================
   assign element_status_word = status_ff;
   assign compute_allow = compute_req && (status_ff[`SW_ENABLE] || compute_exempt);  // [R05]
   assign mem_allow     = mem_req && (status_ff[`SW_MEM_PERMIT] || mem_exempt);      // [R06]
   assign limit_hit     = !supervisor && (mem_addr >= limit_addr);                   // [R21]
   assign region_fault  = mem_access && limit_hit;                                   // [R22]

   // Floating-point flag update per mode
   always @* begin
      fp_new = 5'h00;
      fp_new[1] = fp_invalid || (ieee_mode && fp_div_zero && fp_zero_dividend); // [R14] [R15]
      fp_new[2] = fp_div_zero && !(ieee_mode && fp_zero_dividend);              // [R15]
      fp_new[3] = fp_underflow;                                                 // [R14]
      fp_new[4] = fp_overflow;                                                  // [R14]
      fp_new[0] = 1'b0;                                                         // [R13]
      fp_set = fp_op ? fp_new : 5'h00;
   end

   // Next status word
   always @* begin
      nxt_status = status_ff;
      sw_wr   = special_register_bank_wr && (special_register_bank_wr_idx == `SPECIAL_REGISTER_BANK_STATUS_IDX);
      wr_mask = supervisor ? `SW_WRITE_MASK : (`SW_USER_MASK & `SW_WRITE_MASK); // [R16]
      // Explicit special move first; hardware events below win over it
      if (sw_wr)
         nxt_status = (status_ff & ~wr_mask) | (special_register_bank_wr_data & wr_mask);          // [R11] [R16]
      nxt_status[`SW_ACC_LSB] = acc_lsb;                                         // [R03]
      if (cc_wr)
         nxt_status[`SW_NEGATIVE:`SW_CARRY] = cc_in;                              // [R03]
      if (logic_wr)
         nxt_status[`SW_LOGIC] = logic_in;                                        // [R04]
      if (router_open && router_connected)
         nxt_status[`SW_TRANSMIT] = 1'b0;                                         // [R07]
      if (router_recv)
         nxt_status[`SW_RECEIVE] = 1'b1;                                          // [R08]
      if (router_fetch_op)
         nxt_status[`SW_FETCH] = router_fetch_ok;                                 // [R09]
      if (fp_op) begin
         if (ieee_mode)
            nxt_status[`SW_FP_OVERFLOW:`SW_FP_LO] =
               nxt_status[`SW_FP_OVERFLOW:`SW_FP_LO] | fp_new;                   // [R11]
         else
            nxt_status[`SW_FP_OVERFLOW:`SW_FP_LO] = fp_new;                       // [R12]
      end
      nxt_status[`SW_INEXACT] = 1'b0;                                            // [R13]
      if (mesh_op)
         nxt_status[`SW_MESH_PAR] = mesh_parity;                                  // [R17]
      if (router_op)
         nxt_status[`SW_ROUTER_PAR] = router_parity;                              // [R18]
      if (mem_access && ecc_hard)
         nxt_status[`SW_ECC_HARD] = 1'b1;                                         // [R19]
      if (mem_access && ecc_soft)
         nxt_status[`SW_ECC_SOFT] = 1'b1;                                         // [R20]
      if (indirect_access)
         nxt_status[`SW_ADDR_LIMIT] = limit_hit;                                  // [R21]
      nxt_status[31:21] = 11'h000;                                               // [R16]
   end

   // Status word register
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         status_ff <= `SW_RESET;
      else if (clk_en)
         status_ff <= nxt_status;                                                 // [R01]
   end

   // Fault and machine status requests, sticky until reset
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_code_word_ff           <= 5'h00;
         mesh_parity_fault_ff         <= 1'b0;
         router_parity_fault_ff       <= 1'b0;
         address_limit_error_ff       <= 1'b0;
         uncorrectable_status_flag_ff <= 1'b0;
         soft_error_status_flag_ff    <= 1'b0;
         soft_threshold_flag_ff       <= 1'b0;
      end else if (clk_en) begin
         fault_code_word_ff <= fault_code_word_ff | (fp_set & fault_mask_word); // [R10]
         if (mesh_op && mesh_parity)
            mesh_parity_fault_ff <= 1'b1;                                         // [R17]
         if (router_op && router_parity)
            router_parity_fault_ff <= 1'b1;                                       // [R18]
         if ((indirect_access && limit_hit) || region_fault)
            address_limit_error_ff <= 1'b1;                                       // [R21] [R22]
         if (mem_access && ecc_hard)
            uncorrectable_status_flag_ff <= 1'b1;                                 // [R19]
         if (mem_access && ecc_soft) begin
            soft_error_status_flag_ff <= 1'b1;                                    // [R20]
            if (soft_error_count >= soft_threshold)
               soft_threshold_flag_ff <= 1'b1;                                    // [R20]
         end
      end
   end

   // Special register read, status word filtered by mode
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         special_register_bank_rd_data_ff <= 32'h00000000;
      else if (clk_en)
         special_register_bank_rd_data_ff <= (special_register_bank_rd_idx == `SPECIAL_REGISTER_BANK_STATUS_IDX) ?
                            user_view(status_ff, supervisor) : srb_rd_data;      // [R16]
   end
endmodule // pe_status_word_flags

/* sim/acu_fault_collector.sv */
// Array control unit side: gathers fault and machine status requests of one element
`timescale 1ns/1ps
module acu_fault_collector (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [10:0] fault_req,
   output logic [10:0] fault_log_ff
);
   // Any request seen stays logged until reset
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         fault_log_ff <= 11'h000;
      else
         fault_log_ff <= fault_log_ff | fault_req;
   end
endmodule // acu_fault_collector

/* sim/pe_status_word_flags_properties.sv */
// Port-level checks of the element status word block
`timescale 1ns/1ps
module pe_status_word_flags_properties (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        clk_en,
   input wire        supervisor,
   input wire        ieee_mode,
   input wire        acc_lsb,
   input wire        compute_req,
   input wire        compute_exempt,
   input wire        mem_req,
   input wire        mem_exempt,
   input wire        fp_op,
   input wire        fp_overflow,
   input wire [4:0]  fault_mask_word,
   input wire        mesh_op,
   input wire        mesh_parity,
   input wire        indirect_access,
   input wire [31:0] mem_addr,
   input wire [31:0] limit_addr,
   input wire        special_register_bank_wr,
   input wire [31:0] element_status_word,
   input wire        compute_allow,
   input wire        mem_allow,
   input wire [4:0]  fault_code_word_ff,
   input wire        mesh_parity_fault_ff,
   input wire        address_limit_error_ff
);
   // ==========================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_acc_mirror: assert property (clk_en |=> element_status_word[0] == $past(acc_lsb))
      else $error("Accumulator bit not mirrored");
   a_freeze_state: assert property (!clk_en |=> $stable(element_status_word))
      else $error("Status word moved while frozen");
   a_inexact_zero: assert property (element_status_word[11] == 1'b0)
      else $error("Inexact flag set");
   a_reserved_zero: assert property (element_status_word[31:21] == 11'h000)
      else $error("Reserved status bits set");
   a_compute_gate: assert property (compute_allow == (compute_req & (element_status_word[6] | compute_exempt)))
      else $error("Compute permit wrong");
   a_mem_gate: assert property (mem_allow == (mem_req & (element_status_word[7] | mem_exempt)))
      else $error("Memory permit wrong");
   a_mesh_write: assert property (clk_en && mesh_op |=> element_status_word[16] == $past(mesh_parity) && (mesh_parity_fault_ff || !$past(mesh_parity)))
      else $error("Mesh parity bit or fault wrong");
   a_fp_fault: assert property (clk_en && fp_op && fp_overflow && fault_mask_word[4] |=> fault_code_word_ff[4] && element_status_word[15])
      else $error("Overflow fault not raised");
   a_ieee_sticky: assert property (clk_en && fp_op && ieee_mode && !special_register_bank_wr |=> (element_status_word & $past(element_status_word) & 32'h0000f000) == ($past(element_status_word) & 32'h0000f000))
      else $error("Flag cleared in ieee mode");
   a_limit_user: assert property (clk_en && indirect_access && !supervisor && mem_addr >= limit_addr |=> element_status_word[20] && address_limit_error_ff)
      else $error("User limit error missed");
   a_limit_super: assert property (clk_en && indirect_access && supervisor |=> !element_status_word[20])
      else $error("Supervisor limit bit set");
   a_fault_hold: assert property (mesh_parity_fault_ff |=> mesh_parity_fault_ff)
      else $error("Mesh fault dropped");
endmodule // pe_status_word_flags_properties
bind pe_status_word_flags pe_status_word_flags_properties i_props (.*);

/* sim/test_pe_status_word_flags.sv */
// Random self-checking bench of the element status word block
`timescale 1ns/1ps
module test_pe_status_word_flags;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en, supervisor, ieee_mode, acc_lsb, cc_wr, logic_wr, logic_in, compute_req;
   logic        compute_exempt, mem_req, mem_exempt, router_open, router_connected, router_recv;
   logic        router_fetch_op, router_fetch_ok, fp_op, fp_invalid, fp_div_zero, fp_zero_dividend;
   logic        fp_underflow, fp_overflow, mesh_op, mesh_parity, router_op, router_parity;
   logic        mem_access, ecc_hard, ecc_soft, indirect_access, special_register_bank_wr, greg_wr, greg_align_err;
   logic        compute_allow, mem_allow, mesh_parity_fault_ff, router_parity_fault_ff;
   logic        address_limit_error_ff, uncorrectable_status_flag_ff, soft_error_status_flag_ff;
   logic        soft_threshold_flag_ff, lim;
   logic [3:0]  cc_in, fp;
   logic [4:0]  fault_mask_word, special_register_bank_wr_idx, special_register_bank_rd_idx, fault_code_word_ff;
   logic [15:0] soft_error_count, soft_threshold;
   logic [31:0] mem_addr, limit_addr, special_register_bank_wr_data, special_register_bank_rd_data_ff, element_status_word;
   logic [31:0] m_sw, m_rd, msk, r, q;
   logic [2:0]  greg_wr_size, greg_rd_size;
   logic [10:0] greg_wr_addr, greg_rd_addr, fault_log_ff, got_f, m_f;
   logic [63:0] greg_wr_data, greg_rd_data;
   int          error_cnt = 0;
   int          comparisons = 0;

   pe_status_word_flags i_pe_status_word_flags (.*);
   acu_fault_collector i_acu_fault_collector (.sys_clk(sys_clk), .rst_n(rst_n),
      .fault_req(got_f), .fault_log_ff(fault_log_ff));
   assign got_f = {soft_threshold_flag_ff, soft_error_status_flag_ff, uncorrectable_status_flag_ff,
      address_limit_error_ff, router_parity_fault_ff, mesh_parity_fault_ff, fault_code_word_ff};

   always #2.5 sys_clk = ~sys_clk;

   // ==========================
   // Reference model
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         m_sw = 32'h0;
         m_f = 11'h0;
         m_rd = 32'h0;
      end else if (clk_en) begin
         m_rd = supervisor ? m_sw : (m_sw & 32'h0000ffff);
         msk = supervisor ? 32'h001ff7ff : 32'h0000f7ff;
         if (special_register_bank_wr && special_register_bank_wr_idx == 5'h00) m_sw = (m_sw & ~msk) | (special_register_bank_wr_data & msk);
         m_sw[0] = acc_lsb;
         if (cc_wr) m_sw[4:1] = cc_in;
         if (logic_wr) m_sw[5] = logic_in;
         if (router_open && router_connected) m_sw[8] = 1'b0;
         if (router_recv) m_sw[9] = 1'b1;
         if (router_fetch_op) m_sw[10] = router_fetch_ok;
         if (fp_op) begin
            fp = {fp_overflow, fp_underflow, fp_div_zero & !(ieee_mode & fp_zero_dividend),
               fp_invalid | (ieee_mode & fp_div_zero & fp_zero_dividend)};
            m_sw[15:12] = ieee_mode ? (m_sw[15:12] | fp) : fp;
            m_f[4:1] = m_f[4:1] | (fp & fault_mask_word[4:1]);
         end
         if (mesh_op) begin
            m_sw[16] = mesh_parity;
            m_f[5] = m_f[5] | mesh_parity;
         end
         if (router_op) begin
            m_sw[17] = router_parity;
            m_f[6] = m_f[6] | router_parity;
         end
         if (mem_access && ecc_hard) begin
            m_sw[18] = 1'b1;
            m_f[8] = 1'b1;
         end
         if (mem_access && ecc_soft) begin
            m_sw[19] = 1'b1;
            m_f[9] = 1'b1;
            if (soft_error_count >= soft_threshold) m_f[10] = 1'b1;
         end
         lim = !supervisor && (mem_addr >= limit_addr);
         if (indirect_access) m_sw[20] = lim;
         if ((indirect_access || mem_access) && lim) m_f[7] = 1'b1;
      end
   end

   // ==========================
   // Tasks
   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rnd_in();
      r = $urandom;
      q = $urandom;
      {clk_en, supervisor, ieee_mode, acc_lsb, cc_in, logic_in, compute_req, compute_exempt,
       mem_req, mem_exempt, router_connected, router_fetch_ok, fp_invalid, fp_div_zero,
       fp_zero_dividend, fp_underflow, fp_overflow, mesh_parity, router_parity, ecc_hard,
       ecc_soft} = r[23:0];
      special_register_bank_wr = rst_n && (r[31:29] == 3'h0);
      {cc_wr, logic_wr, router_open, router_recv, router_fetch_op, fp_op, mesh_op, router_op,
       mem_access, indirect_access} = q[9:0] & q[19:10] & {10{rst_n}};
      fault_mask_word = q[24:20];
      soft_error_count = {13'h0, q[27:25]};
      soft_threshold = {13'h0, r[26:24]};
      mem_addr = $urandom % 64;
      limit_addr = $urandom % 64;
      special_register_bank_wr_data = $urandom;
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================
   // Main sequence
   initial begin
      void'($urandom(32'h763bddfe));
      rnd_in();
      {special_register_bank_wr_idx, special_register_bank_rd_idx, greg_wr, greg_wr_addr, greg_rd_addr} = 33'h0;
      {greg_wr_size, greg_rd_size, greg_wr_data} = {3'h4, 3'h4, 64'h0};
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3000) begin
         @(negedge sys_clk);
         check("status_low", 64'(m_sw[10:0]), 64'(element_status_word[10:0]));
         check("status_fp", 64'(m_sw[15:11]), 64'(element_status_word[15:11]));
         check("status_err", 64'(m_sw[31:16]), 64'(element_status_word[31:16]));
         check("special_register_bank_read", 64'(m_rd), 64'(special_register_bank_rd_data_ff));
         check("faults", 64'(m_f), 64'(got_f));
         check("allow", 64'({compute_req & (m_sw[6] | compute_exempt),
            mem_req & (m_sw[7] | mem_exempt)}), 64'({compute_allow, mem_allow}));
         rnd_in();
      end
      @(negedge sys_clk);
      {cc_wr, logic_wr, router_open, router_recv, router_fetch_op, fp_op, mesh_op, router_op,
       mem_access, indirect_access} = 10'h000;
      {clk_en, supervisor, special_register_bank_wr, special_register_bank_wr_idx, special_register_bank_wr_data} = {3'b111, 5'h1f, 32'h5a5ac3c3};
      {greg_wr, greg_wr_addr, greg_wr_data} = {1'b1, 11'd1216, 64'h0123456789abcdef};
      @(negedge sys_clk);
      check("collector", 64'(m_f), 64'(fault_log_ff));
      {special_register_bank_wr, special_register_bank_rd_idx} = {1'b0, 5'h1f};
      {greg_wr_size, greg_wr_addr, greg_wr_data} = {3'h1, 11'd1224, 64'hee};
      @(negedge sys_clk);
      check("special_register_bank_entry", 64'h5a5ac3c3, 64'(special_register_bank_rd_data_ff));
      {greg_wr, greg_rd_addr, greg_rd_size} = {1'b0, 11'd1216, 3'h4};
      @(negedge sys_clk);
      check("greg_read", 64'h0123456789abeeef, greg_rd_data);
      {greg_rd_addr, greg_rd_size} = {11'd1217, 3'h2};
      @(negedge sys_clk);
      check("greg_align", 64'h1, 64'(greg_align_err));
      tally_and_finish();
   end
endmodule // test_pe_status_word_flags
